// *** mip_intc.sv ***
// interrupt enable, priority, timer flags and internal vector logic
`timescale 1ns/1ps

module mip_intc
    import mip_pkg::*;
(
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // register access
    input wire mip_sfr_req_t i_sfr,
    output logic [7:0] o_sfr_rdata,
    // core vectoring
    input wire mip_core_evt_t i_core,
    output logic o_irq_valid,
    output logic o_irq_high,
    output mip_src_t o_irq_src,
    // sources
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    input wire logic i_serial_irq,
    input wire logic i_kernel_tick_irq,
    input wire logic i_src_event,
    input wire logic [3:0] i_src_group,
    input wire logic [2:0] i_src_index,
    // reset events
    input wire logic i_watchdog_rst,
    input wire logic i_usb_bus_rst,
    input wire logic i_usb_reset_propagate,
    // status
    output logic o_timer0_run,
    output logic o_timer1_run,
    output logic o_internal_agg_request_b
);
    `include "mip_defines.svh"

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] timer_run_and_overflow;
        logic [7:0] core_interrupt_enable;
        logic [7:0] core_interrupt_priority;
        logic [7:0] kernel_tick_enable;
        logic [7:0] kernel_tick_priority;
        logic hi_active;
        logic lo_active;
        mip_irq_t irq;
        logic [7:0] rdata;
        logic agg_b;
    } mip_state_t;

    mip_state_t st_reg;
    mip_state_t st_next;

    logic soft_clear;
    logic q_pending;
    logic [7:0] head_vector;
    logic vec_write;
    logic [4:0] req;
    logic [4:0] prio;
    logic [4:0] hi_set;
    logic [4:0] lo_set;
    logic ack_t0;
    logic ack_t1;

    // ----------------------------------------------------------------
    // reset events and vector queue
    // ----------------------------------------------------------------

    // watchdog always clears, usb reset only when propagated
    assign soft_clear = i_watchdog_rst |
        (i_usb_bus_rst & i_usb_reset_propagate);
    assign vec_write = i_sfr.wr && i_sfr.addr == `MIP_ADDR_VEC;

    mip_vector_queue u_queue (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en),
        .i_clear(soft_clear),
        .i_push(i_src_event),
        .i_push_group(i_src_group),
        .i_push_index(i_src_index),
        .i_pop(vec_write),
        .o_head_vector(head_vector),
        .o_pending(q_pending)
    );

    // ----------------------------------------------------------------
    // request gating and priority
    // ----------------------------------------------------------------

    // per-source request after its own enable
    always_comb
    begin
        req[0] = st_reg.timer_run_and_overflow[`MIP_BIT_OVF0] &
            st_reg.core_interrupt_enable[`MIP_BIT_T0];
        req[1] = st_reg.timer_run_and_overflow[`MIP_BIT_OVF1] &
            st_reg.core_interrupt_enable[`MIP_BIT_T1];
        req[2] = i_serial_irq &
            st_reg.core_interrupt_enable[`MIP_BIT_SER];
        req[3] = q_pending &
            st_reg.core_interrupt_enable[`MIP_BIT_AGG];
        req[4] = i_kernel_tick_irq &
            st_reg.kernel_tick_enable[`MIP_BIT_KTK];
        if (!st_reg.core_interrupt_enable[`MIP_BIT_GLOBAL])
        begin
            req = 5'h00;
        end
        prio[0] = st_reg.core_interrupt_priority[`MIP_BIT_T0];
        prio[1] = st_reg.core_interrupt_priority[`MIP_BIT_T1];
        prio[2] = st_reg.core_interrupt_priority[`MIP_BIT_SER];
        prio[3] = st_reg.core_interrupt_priority[`MIP_BIT_AGG];
        prio[4] = st_reg.kernel_tick_priority[`MIP_BIT_KTK];
        hi_set = req & prio;
        lo_set = req & ~prio;
    end

    // vectoring to a timer routine clears that overflow flag
    assign ack_t0 = i_core.ack && st_reg.irq.valid &&
        st_reg.irq.src == MIP_SRC_T0;
    assign ack_t1 = i_core.ack && st_reg.irq.valid &&
        st_reg.irq.src == MIP_SRC_T1;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        // register writes
        if (i_sfr.wr)
        begin
            unique case (i_sfr.addr)
                `MIP_ADDR_TIMER_CTL:
                    st_next.timer_run_and_overflow =
                        i_sfr.wdata & `MIP_WMASK_TIMER_CTL;
                `MIP_ADDR_ENABLE:
                    st_next.core_interrupt_enable =
                        i_sfr.wdata & `MIP_WMASK_ENABLE;
                `MIP_ADDR_PRIO:
                    st_next.core_interrupt_priority =
                        i_sfr.wdata & `MIP_WMASK_PRIO;
                `MIP_ADDR_TICK_EN:
                    st_next.kernel_tick_enable =
                        i_sfr.wdata & `MIP_WMASK_K;
                `MIP_ADDR_TICK_PRIO:
                    st_next.kernel_tick_priority =
                        i_sfr.wdata & `MIP_WMASK_K;
                default:
                    st_next.rdata = st_reg.rdata;
            endcase
        end
        // flag clear on vectoring, overflow set wins over that clear and a write, soft_clear wins over overflow set
        if (ack_t0)
        begin
            st_next.timer_run_and_overflow[`MIP_BIT_OVF0] = 1'b0;
        end
        if (ack_t1)
        begin
            st_next.timer_run_and_overflow[`MIP_BIT_OVF1] = 1'b0;
        end
        if (i_timer0_ovf)
        begin
            st_next.timer_run_and_overflow[`MIP_BIT_OVF0] = 1'b1;
        end
        if (i_timer1_ovf)
        begin
            st_next.timer_run_and_overflow[`MIP_BIT_OVF1] = 1'b1;
        end
        // register reads, vector shows the queue head
        if (i_sfr.rd)
        begin
            unique case (i_sfr.addr)
                `MIP_ADDR_TIMER_CTL:
                    st_next.rdata = st_reg.timer_run_and_overflow;
                `MIP_ADDR_ENABLE:
                    st_next.rdata = st_reg.core_interrupt_enable;
                `MIP_ADDR_PRIO:
                    st_next.rdata = st_reg.core_interrupt_priority;
                `MIP_ADDR_TICK_EN:
                    st_next.rdata = st_reg.kernel_tick_enable;
                `MIP_ADDR_TICK_PRIO:
                    st_next.rdata = st_reg.kernel_tick_priority;
                `MIP_ADDR_VEC:
                    st_next.rdata = head_vector;
                default:
                    st_next.rdata = `MIP_RESET_REG;
            endcase
        end
        // in-service levels follow vectoring and return
        if (i_core.reti)
        begin
            if (st_reg.hi_active)
            begin
                st_next.hi_active = 1'b0;
            end
            else
            begin
                st_next.lo_active = 1'b0;
            end
        end
        if (i_core.ack && st_reg.irq.valid)
        begin
            if (st_reg.irq.high)
            begin
                st_next.hi_active = 1'b1;
            end
            else
            begin
                st_next.lo_active = 1'b1;
            end
        end
        // pick the request: high preempts low, fixed order within level
        st_next.irq = '0;
        if (!st_reg.hi_active && hi_set != 5'h00)
        begin
            st_next.irq.valid = 1'b1;
            st_next.irq.high = 1'b1;
            for (int i = 4; i >= 0; i--)
            begin
                if (hi_set[i])
                begin
                    st_next.irq.src = mip_src_t'(i[2:0]);
                end
            end
        end
        else if (!st_reg.hi_active && !st_reg.lo_active &&
            lo_set != 5'h00)
        begin
            st_next.irq.valid = 1'b1;
            for (int i = 4; i >= 0; i--)
            begin
                if (lo_set[i])
                begin
                    st_next.irq.src = mip_src_t'(i[2:0]);
                end
            end
        end
        // no second request in the cycle after a take
        if (i_core.ack)
        begin
            st_next.irq = '0;
        end
        // level request, low while any internal source waits
        st_next.agg_b = ~q_pending;
        // watchdog or propagated usb reset clears control state
        if (soft_clear)
        begin
            st_next.timer_run_and_overflow = `MIP_RESET_REG;
            st_next.core_interrupt_enable = `MIP_RESET_REG;
            st_next.core_interrupt_priority = `MIP_RESET_REG;
            st_next.kernel_tick_enable = `MIP_RESET_REG;
            st_next.kernel_tick_priority = `MIP_RESET_REG;
            st_next.hi_active = 1'b0;
            st_next.lo_active = 1'b0;
            st_next.irq = '0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_reg <= '0;
            st_reg.agg_b <= 1'b1;
        end
        else if (i_clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign o_sfr_rdata = st_reg.rdata;
    assign o_irq_valid = st_reg.irq.valid;
    assign o_irq_high = st_reg.irq.high;
    assign o_irq_src = st_reg.irq.src;
    assign o_timer0_run = st_reg.timer_run_and_overflow[`MIP_BIT_RUN0];
    assign o_timer1_run = st_reg.timer_run_and_overflow[`MIP_BIT_RUN1];
    assign o_internal_agg_request_b = st_reg.agg_b;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_global_gate: assert property (
        (i_clk_en && !st_reg.core_interrupt_enable[7]) |=> !o_irq_valid)
        else $error("request with global enable off");

    a_t0_gate: assert property (
        (i_clk_en && !st_reg.core_interrupt_enable[1])
        |=> !(o_irq_valid && o_irq_src == MIP_SRC_T0))
        else $error("timer0 request while disabled");

    a_agg_gate: assert property (
        (i_clk_en && !st_reg.core_interrupt_enable[5])
        |=> !(o_irq_valid && o_irq_src == MIP_SRC_AGG))
        else $error("internal request while disabled");

    a_reserved_zero: assert property (
        st_reg.timer_run_and_overflow[3:0] == 4'h0 &&
        st_reg.kernel_tick_enable[7:1] == 7'h00 &&
        st_reg.kernel_tick_priority[7:1] == 7'h00)
        else $error("reserved bits not zero");

    a_ovf_set: assert property (
        (i_clk_en && i_timer0_ovf && !soft_clear)
        |=> st_reg.timer_run_and_overflow[5])
        else $error("timer0 overflow flag not set");

    a_ovf_clear: assert property (
        (i_clk_en && ack_t0 && !i_timer0_ovf)
        |=> !st_reg.timer_run_and_overflow[5])
        else $error("timer0 flag not cleared on vectoring");

    a_agg_level: assert property (
        i_clk_en |=> (o_internal_agg_request_b == !$past(q_pending)))
        else $error("internal request level wrong");

    a_queue_clear: assert property (
        (i_clk_en && soft_clear) |=> !q_pending ##1 o_internal_agg_request_b)
        else $error("queue not cleared by reset event");

    a_preempt_hold: assert property (
        (i_clk_en && st_reg.hi_active) |=> !(o_irq_valid && !o_irq_high))
        else $error("low request during high routine");

    c_preempt: cover property (
        st_reg.lo_active && o_irq_valid && o_irq_high && i_core.ack);
    c_vec_pop: cover property (q_pending && vec_write ##1 q_pending);
    c_usb_clear: cover property (i_usb_bus_rst && i_usb_reset_propagate
        && q_pending);

endmodule

// *** mip_defines.svh ***
// offsets, field positions, masks and reset values of the interrupt block
`ifndef MIP_DEFINES_SVH
`define MIP_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets in the special-function space
// ----------------------------------------------------------------
`define MIP_ADDR_TIMER_CTL 8'h88
`define MIP_ADDR_ENABLE 8'ha8
`define MIP_ADDR_PRIO 8'hb8
`define MIP_ADDR_TICK_EN 8'he8
`define MIP_ADDR_TICK_PRIO 8'hf8
`define MIP_ADDR_VEC 8'hf7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MIP_BIT_GLOBAL 7
`define MIP_BIT_T0 1
`define MIP_BIT_T1 3
`define MIP_BIT_SER 4
`define MIP_BIT_AGG 5
`define MIP_BIT_KTK 0
`define MIP_BIT_RUN0 4
`define MIP_BIT_OVF0 5
`define MIP_BIT_RUN1 6
`define MIP_BIT_OVF1 7

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define MIP_WMASK_ENABLE 8'hba
`define MIP_WMASK_PRIO 8'h3a
`define MIP_WMASK_K 8'h01
`define MIP_WMASK_TIMER_CTL 8'hf0
`define MIP_RESET_REG 8'h00
`define MIP_VEC_NONE 8'h00

// ----------------------------------------------------------------
// vector queue depth
// ----------------------------------------------------------------
`define MIP_QUEUE_DEPTH 8

`endif

// *** mip_pkg.sv ***
// types shared by the interrupt enable and priority block
package mip_pkg;

    // source selected for the core
    typedef enum logic [2:0] {
        MIP_SRC_T0 = 3'h0,
        MIP_SRC_T1 = 3'h1,
        MIP_SRC_SER = 3'h2,
        MIP_SRC_AGG = 3'h3,
        MIP_SRC_KTK = 3'h4
    } mip_src_t;

    // special-function register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mip_sfr_req_t;

    // core vectoring handshake
    typedef struct packed {
        logic ack;
        logic reti;
    } mip_core_evt_t;

    // one pending internal source
    typedef struct packed {
        logic valid;
        logic [3:0] group;
        logic [2:0] index;
    } mip_entry_t;

    // request to the core
    typedef struct packed {
        logic valid;
        logic high;
        mip_src_t src;
    } mip_irq_t;

endpackage

// *** mip_vector_queue.sv ***
// pending queue of internal sources, highest group first, fcfs in group
`timescale 1ns/1ps

module mip_vector_queue
    import mip_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // control
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic [3:0] i_push_group,
    input wire logic [2:0] i_push_index,
    input wire logic i_pop,
    // status
    output logic [7:0] o_head_vector,
    output logic o_pending
);
    `include "mip_defines.svh"

    typedef struct packed {
        mip_entry_t [`MIP_QUEUE_DEPTH-1:0] ent;
    } mip_queue_state_t;

    mip_queue_state_t q_reg;
    mip_queue_state_t q_next;

    logic [2:0] head_pos;
    logic head_ok;
    logic dup;
    logic placed;

    // head search, pop with shift-down, append of new arrivals
    always_comb
    begin
        q_next = q_reg;
        head_pos = 3'h0;
        head_ok = 1'b0;
        dup = 1'b0;
        placed = 1'b0;
        // oldest entry of the highest group wins
        for (int i = 0; i < `MIP_QUEUE_DEPTH; i++)
        begin
            if (q_reg.ent[i].valid && (!head_ok ||
                q_reg.ent[i].group > q_reg.ent[head_pos].group))
            begin
                head_pos = i[2:0];
                head_ok = 1'b1;
            end
        end
        // a write removes the current vector
        if (i_pop && head_ok)
        begin
            for (int i = 0; i < `MIP_QUEUE_DEPTH - 1; i++)
            begin
                if (i >= int'(head_pos))
                begin
                    q_next.ent[i] = q_reg.ent[i+1];
                end
            end
            q_next.ent[`MIP_QUEUE_DEPTH-1] = '0;
        end
        // one copy per source; a full queue drops the arrival
        for (int i = 0; i < `MIP_QUEUE_DEPTH; i++)
        begin
            if (q_next.ent[i].valid &&
                q_next.ent[i].group == i_push_group &&
                q_next.ent[i].index == i_push_index)
            begin
                dup = 1'b1;
            end
        end
        if (i_push && !dup && i_push_group != 4'h0)
        begin
            for (int i = 0; i < `MIP_QUEUE_DEPTH; i++)
            begin
                if (!placed && !q_next.ent[i].valid)
                begin
                    q_next.ent[i] = {1'b1, i_push_group, i_push_index};
                    placed = 1'b1;
                end
            end
        end
        // reset events discard everything pending
        if (i_clear)
        begin
            q_next = '0;
        end
        o_pending = head_ok;
        o_head_vector = head_ok ? {q_reg.ent[head_pos].group,
            q_reg.ent[head_pos].index, 1'b0} : `MIP_VEC_NONE;
    end

    // queue storage
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_reg <= '0;
        end
        else if (i_clk_en)
        begin
            q_reg <= q_next;
        end
    end

endmodule

// *** mip_core_model.sv ***
// core model: takes shown requests and returns after a chosen hold
`timescale 1ns/1ps

module mip_core_model
    import mip_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // bench control
    input wire logic i_enable,
    input wire logic [3:0] i_hold,
    // core side of the block
    input wire logic i_irq_valid,
    output mip_core_evt_t o_core
);
    logic busy_reg;
    logic [3:0] cnt_reg;

    // ack a shown request, then reti once the hold has run out
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= 4'h0;
            o_core <= '0;
        end
        else
        begin
            o_core <= '0;
            if (busy_reg)
            begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg >= i_hold)
                begin
                    o_core.reti <= 1'b1; // ack before reti, one at a time
                    busy_reg <= 1'b0;
                end
            end
            else if (i_enable && i_irq_valid)
            begin
                o_core.ack <= 1'b1;
                busy_reg <= 1'b1;
                cnt_reg <= 4'h0;
            end
        end
    end
endmodule

// *** mip_intc_bench.sv ***
// self-checking bench of the interrupt enable and priority block
`timescale 1ns/1ps

module mip_intc_bench
    import mip_pkg::*;
;
    logic clk, rst_b, ovf0, ovf1, ser, ktk, ev, wdog, usb, prop, pen, ce;
    logic [3:0] grp, hold;
    logic [2:0] idx;
    mip_sfr_req_t sfr;
    mip_core_evt_t core;
    logic [7:0] rdata, rv, d;
    logic irq_v, irq_h, run0, run1, agg_b, h;
    mip_src_t irq_s;
    int miscompares, checks_done, seed, n, k;
    logic [7:0] adr [7] = '{8'h88, 8'ha8, 8'hb8, 8'he8, 8'hf8, 8'hf7, 8'h55};
    logic [7:0] ie_t [5] = '{8'h82, 8'h88, 8'h90, 8'ha0, 8'h80};
    int pb_t [4] = '{1, 3, 4, 5};
    logic [7:0] q_t [4] = '{8'h54, 8'h32, 8'h38, 8'h00};

    mip_intc DUT (.i_sys_clk(clk), .i_rst_b(rst_b), .i_clk_en(ce),
        .i_sfr(sfr), .o_sfr_rdata(rdata), .i_core(core),
        .o_irq_valid(irq_v), .o_irq_high(irq_h), .o_irq_src(irq_s),
        .i_timer0_ovf(ovf0), .i_timer1_ovf(ovf1), .i_serial_irq(ser),
        .i_kernel_tick_irq(ktk), .i_src_event(ev), .i_src_group(grp),
        .i_src_index(idx), .i_watchdog_rst(wdog), .i_usb_bus_rst(usb),
        .i_usb_reset_propagate(prop), .o_timer0_run(run0),
        .o_timer1_run(run1), .o_internal_agg_request_b(agg_b));

    mip_core_model core_model (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_enable(pen), .i_hold(hold), .i_irq_valid(irq_v), .o_core(core));

    // expected values
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'h88: return 8'hf0;
            8'ha8: return 8'hba;
            8'hb8: return 8'h3a;
            8'he8, 8'hf8: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] vec(input logic [3:0] g, input logic [2:0] i);
        return {g, i, 1'b0};
    endfunction

    // comparison and verdict
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task summarize;
        $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // register bus cycles
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr.wr <= 1'b1;
        sfr.addr <= a;
        sfr.wdata <= v;
        @(posedge clk);
        sfr.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr.rd <= 1'b1;
        sfr.addr <= a;
        @(posedge clk);
        sfr.rd <= 1'b0;
        #1 rv = rdata;
        check($sformatf("reg %h", a), e, rv);
    endtask

    // source and reset pulses: 0 ovf0, 1 ovf1, 2 watchdog, 3 usb
    task automatic pulse(input int w);
        @(posedge clk);
        ovf0 <= (w == 0);
        ovf1 <= (w == 1);
        wdog <= (w == 2);
        usb <= (w == 3);
        @(posedge clk);
        {ovf0, ovf1, wdog, usb} <= 4'h0;
    endtask

    task automatic evt(input logic [3:0] g, input logic [2:0] i);
        @(posedge clk);
        ev <= 1'b1;
        grp <= g;
        idx <= i;
        @(posedge clk);
        ev <= 1'b0;
    endtask

    task automatic wait_irq(input mip_src_t s, input logic hi);
        for (n = 0; n < 40; n++)
        begin
            @(negedge clk);
            if (irq_v === 1'b1 && irq_s === s)
                break;
        end
        if (n == 40)
        begin
            miscompares++;
            summarize;
        end
        else
            check("irq_high", {7'h0, hi}, {7'h0, irq_h});
    endtask

    // clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize;
    end

    // main sequence
    initial
    begin
        seed = 79;
        {rst_b, ovf0, ovf1, ser, ktk, ev, wdog, usb, prop, pen} = '0;
        ce = 1'b1;
        grp = 4'h0;
        idx = 3'h0;
        hold = 4'h2;
        sfr = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, unmapped place, empty vector
        for (k = 0; k < 7; k++)
            rd_chk(adr[k], 8'h00);
        // clock enable low: a write is not taken
        @(posedge clk);
        ce <= 1'b0;
        sfr_wr(8'hb8, 8'h3a);
        ce <= 1'b1;
        rd_chk(8'hb8, 8'h00);
        // read-only and reserved bits, all ones then random data
        for (n = 0; n < 20; n++)
        begin
            d = (n < 5) ? 8'hff : 8'($random(seed));
            sfr_wr(adr[n % 5], d);
            rd_chk(adr[n % 5], d & wmask(adr[n % 5]));
        end
        sfr_wr(8'h88, 8'h50);
        @(negedge clk);
        check("timer runs", 8'h03, {6'h0, run1, run0});
        sfr_wr(8'h88, 8'h00);
        @(negedge clk);
        check("timer halts", 8'h00, {6'h0, run1, run0});
        // each source: blocked by global enable, then taken at its level
        for (k = 0; k < 5; k++)
        begin
            h = 1'($random(seed));
            hold <= 4'($random(seed));
            sfr_wr(8'ha8, ie_t[k] & 8'h7f);
            sfr_wr(8'he8, {7'h0, k == 4});
            sfr_wr(8'hb8, (k < 4) ? ({7'h0, h} << pb_t[k]) : 8'h00);
            sfr_wr(8'hf8, {7'h0, h && k == 4});
            @(posedge clk);
            ser <= (k == 2);
            ktk <= (k == 4);
            if (k < 2)
                pulse(k);
            if (k == 3)
                evt(4'h2, 3'h3);
            repeat (6) @(negedge clk);
            check("irq_valid", 8'h00, {7'h0, irq_v});
            if (k < 2)
                rd_chk(8'h88, k ? 8'h80 : 8'h20);
            @(posedge clk);
            pen <= 1'b1;
            sfr_wr(8'ha8, ie_t[k]);
            wait_irq(mip_src_t'(k), h);
            repeat (3) @(posedge clk);
            if (k < 2)
                rd_chk(8'h88, 8'h00);
            if (k == 3)
                rd_chk(8'hf7, 8'h26);
            if (k == 3)
                sfr_wr(8'hf7, 8'h00);
            @(posedge clk);
            {pen, ser, ktk} <= 3'h0;
            repeat (20) @(posedge clk);
            sfr_wr(8'ha8, 8'h00);
        end
        // queue order, duplicate and group 0 dropped
        evt(4'h3, 3'h1);
        evt(4'h5, 3'h2);
        evt(4'h3, 3'h4);
        evt(4'h3, 3'h1);
        evt(4'h0, 3'h5);
        repeat (2) @(negedge clk);
        check("agg_b", 8'h00, {7'h0, agg_b});
        for (k = 0; k < 4; k++)
        begin
            rd_chk(8'hf7, q_t[k]);
            sfr_wr(8'hf7, 8'($random(seed)));
        end
        repeat (3) @(negedge clk);
        check("agg_b", 8'h01, {7'h0, agg_b});
        // random single vectors
        for (k = 0; k < 6; k++)
        begin
            d = 8'($random(seed));
            if (d[3:0] == 4'h0)
                d[3:0] = 4'h1;
            evt(d[3:0], d[6:4]);
            rd_chk(8'hf7, vec(d[3:0], d[6:4]));
            sfr_wr(8'hf7, 8'h00);
        end
        // clearing resets
        evt(4'h4, 3'h4);
        pulse(3);
        rd_chk(8'hf7, 8'h48);
        @(posedge clk);
        prop <= 1'b1;
        pulse(3);
        rd_chk(8'hf7, 8'h00);
        @(posedge clk);
        prop <= 1'b0;
        sfr_wr(8'ha8, 8'hba);
        evt(4'h6, 3'h1);
        evt(4'h7, 3'h2);
        pulse(2);
        rd_chk(8'hf7, 8'h00);
        rd_chk(8'ha8, 8'h00);
        repeat (3) @(negedge clk);
        check("agg_b", 8'h01, {7'h0, agg_b});
        summarize;
    end
endmodule
